// ---- design/slotb_frontend_cfg.sv ----
/*
 * Second-slot front end configuration bank: four 16-bit registers
 * behind a plain strobe port, with decoded control outputs for the
 * analog front end and a pulse polarity sequencer.
 * Assumes register port, pulse strobe and the external gain inputs
 * all come from logic on mclk.
 */
// Decided for this implementation: the plain strobed port.
`default_nettype none

// How it works
// (R1) Order bit n sets pulse n+1 polarity
// (R2) Polarity pattern repeats after pulse four
// (R3) Bit 0 normal, 1 reversed; reset zero
// (R4) Window width bits 15:11, reset 4
// (R5) Window offset bits 10:0, reset 0x17
// (R6) Bit 9 picks buffer gain 1 or 0.7
// (R7) Bit 7 turns integrator into buffer
// (R8) Individual gains: channel 1 here, others external
// (R9) Otherwise one gain for all channels
// (R10) Reference select bits 5:4, reset 3
// (R11) Amplifier gain code 0..3, reset 0
// (R12) Path word resets to full analog
// (R13) Software sets buffer bits before buffered path
// (R14) Direct path word with buffer bit clear
// (R15) Software writes recommended values, no reserved words
// (R16) Fields reset to defaults, reads side-effect free
module slotb_frontend_cfg
  import slotb_cfg_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic        pulse_done,
  input  wire logic [5:0]  ext_ch_gain,
  input  wire logic        ext_aux_buf_en,
  output logic             integ_reverse,
  output logic      [1:0]  pulse_index,
  output logic      [4:0]  window_width,
  output logic      [10:0] window_offset,
  output logic      [5:0]  frontend_mode_field,
  output logic             buffer_gain_select,
  output logic             integrator_buffer_enable,
  output logic             per_channel_gain_enable,
  output logic      [1:0]  amp_reference_select,
  output logic      [7:0]  ch_gain,
  output logic      [15:0] signal_path_select,
  output logic      [1:0]  path_mode,
  output logic             path_config_ok
);

  // ****************************************
  // State
  // ****************************************

  typedef struct packed {
    // Stored register words
    logic [15:0] order_reg;
    logic [15:0] timing_reg;
    logic [15:0] amp_reg;
    logic [15:0] path_reg;
    // Read port and derived outputs
    logic [15:0] rdata;
    logic [7:0]  gains;
    path_mode_t  mode;
    logic        ok;
  } cfg_state_t;

  cfg_state_t state_ff;
  cfg_state_t nxt_state;

  polarity_if pol ();

  // ****************************************
  // Helpers
  // ****************************************

  // Gain code for one channel, 0 = channel 1
  function automatic logic [1:0] chan_gain(
    input logic       ind_en,
    input logic [1:0] common,
    input logic [5:0] ext,
    input logic [1:0] ch
  );
    logic [1:0] g;
    g = common;
    if (ind_en && ch != 2'd0) begin
      g = ext[2*(ch-2'd1) +: 2];
    end
    return g;
  endfunction : chan_gain

  // Classify a path word
  function automatic path_mode_t decode_path(
    input logic [15:0] word
  );
    path_mode_t m;
    m = PM_RESERVED;
    if (word == PATH_FULL_ANALOG) begin
      m = PM_FULL_ANALOG;
    end else if (word == PATH_AMP_ADC_BUF) begin
      m = PM_AMP_ADC_BUF;
    end else if (word == PATH_AMP_ADC_DIR) begin
      m = PM_AMP_ADC_DIR;
    end
    return m;
  endfunction : decode_path

  // Register selected by an address, shared by write and read
  typedef enum logic [2:0] {
    SEL_ORDER  = 3'b000,
    SEL_TIMING = 3'b001,
    SEL_AMP    = 3'b010,
    SEL_PATH   = 3'b011,
    SEL_NONE   = 3'b100
  } reg_sel_t;

  // Exact address compare; anything else is unmapped
  function automatic reg_sel_t decode_addr(
    input logic [7:0] addr
  );
    reg_sel_t s;
    s = SEL_NONE;
    if (addr == OFS_POLARITY_ORDER) begin
      s = SEL_ORDER;
    end else if (addr == OFS_WINDOW_TIMING) begin
      s = SEL_TIMING;
    end else if (addr == OFS_AMP_OPTIONS) begin
      s = SEL_AMP;
    end else if (addr == OFS_PATH_SELECT) begin
      s = SEL_PATH;
    end
    return s;
  endfunction : decode_addr

  // Reset word of each register
  localparam logic [15:0] RST_ORDER_REG = {12'h000, RST_ORDER};
  localparam logic [15:0] RST_TIMING_REG = {RST_WIDTH, RST_OFFSET};
  localparam logic [15:0] RST_AMP_REG = {
    RST_MODE,    // Mode field 15:10
    1'b0,        // Buffer gain unity
    1'b0,        // Reserved bit 8
    1'b0,        // Integrator in normal use
    1'b0,        // One gain for all channels
    RST_VREF,    // Reference level code
    RST_RSVD32,  // Reserved bits 3:2
    RST_GAIN     // Amplifier gain code
  };

  // ****************************************
  // Next-state logic
  // ****************************************

  always_comb begin
    nxt_state = state_ff;
    nxt_state.rdata = 16'h0000;

    // Register writes, all bits stored
    if (reg_wr) begin
      unique case (decode_addr(reg_addr))
        SEL_ORDER: begin
          nxt_state.order_reg = reg_wdata;
        end
        SEL_TIMING: begin
          nxt_state.timing_reg = reg_wdata;
        end
        SEL_AMP: begin
          nxt_state.amp_reg = reg_wdata;
        end
        SEL_PATH: begin
          nxt_state.path_reg = reg_wdata;
        end
        default: begin
          // Unmapped address, write dropped
          nxt_state.rdata = 16'h0000;
        end
      endcase
    end

    // (R16) plain readback
    if (reg_rd) begin
      unique case (decode_addr(reg_addr))
        SEL_ORDER: begin
          nxt_state.rdata = state_ff.order_reg;
        end
        SEL_TIMING: begin
          nxt_state.rdata = state_ff.timing_reg;
        end
        SEL_AMP: begin
          nxt_state.rdata = state_ff.amp_reg;
        end
        SEL_PATH: begin
          nxt_state.rdata = state_ff.path_reg;
        end
        default: begin
          nxt_state.rdata = 16'h0000;
        end
      endcase
    end

    // (R8) individual channel gains
    // (R9) common gain fallback
    // (R11) two-bit gain code
    for (int c = 0; c < 4; c++) begin
      nxt_state.gains[2*c +: 2] = chan_gain(
        nxt_state.amp_reg[INDEN_BIT],
        nxt_state.amp_reg[GAIN_MSB:0],
        ext_ch_gain,
        2'(c)
      );
    end

    // Path decode from the stored word
    nxt_state.mode = decode_path(nxt_state.path_reg);

    // (R14) direct path check
    // (R13) buffered path prerequisites
    unique case (nxt_state.mode)
      PM_FULL_ANALOG: begin
        nxt_state.ok = 1'b1;
      end
      PM_AMP_ADC_BUF: begin
        nxt_state.ok = nxt_state.amp_reg[INTBUF_BIT] & ext_aux_buf_en;
      end
      PM_AMP_ADC_DIR: begin
        nxt_state.ok = ~nxt_state.amp_reg[INTBUF_BIT];
      end
      PM_RESERVED: begin
        nxt_state.ok = 1'b0;
      end
    endcase
  end

  // ****************************************
  // State register
  // ****************************************

  always_ff @(posedge mclk) begin
    if (reset) begin
      // (R3) order resets to zero
      state_ff.order_reg <= RST_ORDER_REG;
      // (R4) width reset 4
      // (R5) offset reset 0x17
      state_ff.timing_reg <= RST_TIMING_REG;
      // (R10) reference reset 3
      state_ff.amp_reg <= RST_AMP_REG;
      // (R12) full analog path
      state_ff.path_reg <= PATH_FULL_ANALOG;
      // Read port idle
      state_ff.rdata <= 16'h0000;
      // (R11) gain code reset 0
      state_ff.gains <= {4{RST_GAIN}};
      // Decode of the reset path word
      state_ff.mode <= PM_FULL_ANALOG;
      state_ff.ok <= 1'b1;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ****************************************
  // Polarity sequencer
  // ****************************************

  // (R1) order field feeds sequencer
  assign pol.order      = state_ff.order_reg[ORDER_MSB:0];
  assign pol.pulse_done = pulse_done;

  pulse_polarity_seq u_seq (
    .mclk  (mclk),
    .reset (reset),
    .pol   (pol.seq)
  );

  // ****************************************
  // Outputs
  // ****************************************

  // Register port readback
  assign reg_rdata = state_ff.rdata;

  // Pulse polarity, flops inside sequencer
  assign integ_reverse = pol.reverse;
  assign pulse_index   = pol.index;

  // (R4) width in 1 us units
  assign window_width = state_ff.timing_reg[WIDTH_MSB:WIDTH_LSB];
  // (R5) offset in 31.25 ns units
  assign window_offset = state_ff.timing_reg[OFFSET_MSB:0];

  // Amplifier option fields
  assign frontend_mode_field = state_ff.amp_reg[MODE_MSB:MODE_LSB];
  // (R6) buffer gain select
  assign buffer_gain_select = state_ff.amp_reg[BUFGAIN_BIT];
  // (R7) integrator as buffer
  assign integrator_buffer_enable = state_ff.amp_reg[INTBUF_BIT];
  // (R8) per-channel gain enable
  assign per_channel_gain_enable = state_ff.amp_reg[INDEN_BIT];
  // (R10) reference level code
  assign amp_reference_select = state_ff.amp_reg[VREF_MSB:VREF_LSB];

  // Per-channel gains, channel 1 in low bits
  assign ch_gain = state_ff.gains;

  // Path word and its decode
  // Reserved words are kept as written; the PM_RESERVED decode and
  // the cleared flag below tell the front end not to act on them
  assign signal_path_select = state_ff.path_reg;
  assign path_mode          = state_ff.mode;
  assign path_config_ok     = state_ff.ok;

endmodule : slotb_frontend_cfg

`default_nettype wire

// ---- design/slotb_cfg_pkg.sv ----
/*
 * Constants for the second-slot front end configuration bank:
 * register offsets, field positions, reset values and path words.
 * Assumes a 16-bit register word and an 8-bit register address.
 */
`default_nettype none

package slotb_cfg_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] OFS_POLARITY_ORDER = 8'h1d;
  localparam logic [7:0] OFS_WINDOW_TIMING  = 8'h3b;
  localparam logic [7:0] OFS_AMP_OPTIONS    = 8'h44;
  localparam logic [7:0] OFS_PATH_SELECT    = 8'h45;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int ORDER_MSB   = 3;
  localparam int WIDTH_MSB   = 15;
  localparam int WIDTH_LSB   = 11;
  localparam int OFFSET_MSB  = 10;
  localparam int MODE_MSB    = 15;
  localparam int MODE_LSB    = 10;
  localparam int BUFGAIN_BIT = 9;
  localparam int INTBUF_BIT  = 7;
  localparam int INDEN_BIT   = 6;
  localparam int VREF_MSB    = 5;
  localparam int VREF_LSB    = 4;
  localparam int GAIN_MSB    = 1;

  // ****************************************
  // Field reset values
  // ****************************************
  localparam logic [3:0]  RST_ORDER  = 4'h0;
  localparam logic [4:0]  RST_WIDTH  = 5'h04;
  localparam logic [10:0] RST_OFFSET = 11'h017;
  localparam logic [5:0]  RST_MODE   = 6'h07;
  localparam logic [1:0]  RST_VREF   = 2'h3;
  localparam logic [1:0]  RST_RSVD32 = 2'h2;
  localparam logic [1:0]  RST_GAIN   = 2'h0;

  // ****************************************
  // Signal path words
  // ****************************************
  localparam logic [15:0] PATH_FULL_ANALOG = 16'hada5;
  localparam logic [15:0] PATH_AMP_ADC_BUF = 16'hae65;
  localparam logic [15:0] PATH_AMP_ADC_DIR = 16'hb065;

  // Decoded path selection
  typedef enum logic [1:0] {
    PM_FULL_ANALOG = 2'b00,
    PM_AMP_ADC_BUF = 2'b01,
    PM_AMP_ADC_DIR = 2'b10,
    PM_RESERVED    = 2'b11
  } path_mode_t;

endpackage : slotb_cfg_pkg

`default_nettype wire

// ---- design/polarity_if.sv ----
/*
 * Link between the register bank and the pulse polarity sequencer.
 * Assumes both ends run on the same clock.
 */
`default_nettype none

interface polarity_if;
  logic [3:0] order;       // Polarity bit per pulse
  logic       pulse_done;  // One-cycle end-of-pulse strobe
  logic       reverse;     // Polarity of the current pulse
  logic [1:0] index;       // Current pulse, 0 = pulse 1

  modport seq (input order, input pulse_done, output reverse, output index);
  modport ctl (output order, output pulse_done, input reverse, input index);
endinterface : polarity_if

`default_nettype wire

// ---- design/pulse_polarity_seq.sv ----
/*
 * Steps through a four-pulse group and presents the integration
 * polarity of the current pulse. Assumes pulse_done is a one-cycle
 * strobe on mclk.
 */
`default_nettype none

module pulse_polarity_seq
  import slotb_cfg_pkg::*;
(
  input  wire logic mclk,
  input  wire logic reset,
  polarity_if.seq   pol
);

  typedef struct packed {
    logic [1:0] idx;
    logic       rev;
  } seq_state_t;

  seq_state_t state_ff;
  seq_state_t nxt_state;

  // Advance pulse index, wrap after pulse 4
  always_comb begin
    nxt_state = state_ff;
    // (R2) wrap to pulse 1
    if (pol.pulse_done) begin
      nxt_state.idx = state_ff.idx + 2'd1;
    end
    // (R1) bit per pulse
    // (R3) 1 means reversed
    nxt_state.rev = pol.order[nxt_state.idx];
  end

  // State register
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign pol.reverse = state_ff.rev;
  assign pol.index   = state_ff.idx;

endmodule : pulse_polarity_seq

`default_nettype wire

// ---- tb/slotb_frontend_cfg_properties.sv ----
/* Port checker for the slot B configuration bank.
   Assumes one clock and a synchronous active-high reset. */
`default_nettype none

// *****
// Checker
// *****
module slotb_cfg_props
  import slotb_cfg_pkg::*;
(
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        pulse_done,
  input wire logic [5:0]  ext_ch_gain,
  input wire logic        ext_aux_buf_en,
  input wire logic [1:0]  pulse_index,
  input wire logic [4:0]  window_width,
  input wire logic [10:0] window_offset,
  input wire logic        integrator_buffer_enable,
  input wire logic        per_channel_gain_enable,
  input wire logic [7:0]  ch_gain,
  input wire logic [15:0] signal_path_select,
  input wire logic [1:0]  path_mode,
  input wire logic        path_config_ok
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  // Read port and stored words
  rdata_idle_a: assert property (
    !reg_rd |=> reg_rdata == 16'h0000) else $error("read data not idle");
  timing_read_a: assert property (
    reg_rd && reg_addr == OFS_WINDOW_TIMING |=>
    reg_rdata == {$past(window_width), $past(window_offset)}) else $error("timing read");
  path_read_a: assert property (
    reg_rd && reg_addr == OFS_PATH_SELECT |=>
    reg_rdata == $past(signal_path_select)) else $error("path read");

  // Pulse stepping and gains
  pulse_step_a: assert property (
    pulse_done |=> pulse_index == 2'($past(pulse_index) + 2'd1)) else $error("pulse step");
  common_gain_a: assert property (
    !per_channel_gain_enable |-> ch_gain == {4{ch_gain[1:0]}}) else $error("common gain");
  own_gain_a: assert property (
    per_channel_gain_enable |-> ch_gain[7:2] == $past(ext_ch_gain)) else $error("own gain");

  // Path decode
  full_path_a: assert property (
    signal_path_select == PATH_FULL_ANALOG |-> path_mode == PM_FULL_ANALOG && path_config_ok)
    else $error("full path");
  direct_path_a: assert property (
    signal_path_select == PATH_AMP_ADC_DIR |-> path_mode == PM_AMP_ADC_DIR &&
    path_config_ok == !integrator_buffer_enable) else $error("direct path");
  buf_path_a: assert property (
    signal_path_select == PATH_AMP_ADC_BUF |-> path_mode == PM_AMP_ADC_BUF &&
    path_config_ok == (integrator_buffer_enable && $past(ext_aux_buf_en)))
    else $error("buffered path");
  rsvd_path_a: assert property (
    path_mode == PM_RESERVED |-> !path_config_ok) else $error("reserved path");
endmodule : slotb_cfg_props

bind slotb_frontend_cfg slotb_cfg_props u_props (
  .mclk, .reset, .reg_addr, .reg_rd, .reg_rdata, .pulse_done, .ext_ch_gain,
  .ext_aux_buf_en, .pulse_index, .window_width, .window_offset,
  .integrator_buffer_enable, .per_channel_gain_enable, .ch_gain,
  .signal_path_select, .path_mode, .path_config_ok);

`default_nettype wire

// ---- tb/slotb_frontend_cfg_tb_top.sv ----
/* Self-checking bench for the slot B configuration bank.
   Assumes the bank answers reads one cycle later with no wait. */
`default_nettype none

// *****
// Bench
// *****
module slotb_frontend_cfg_tb_top
  import slotb_cfg_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk, reset, reg_wr, reg_rd, pulse_done, ext_aux_buf_en;
  logic [7:0]  reg_addr, ch_gain;
  logic [15:0] reg_wdata, reg_rdata, signal_path_select, d;
  logic [5:0]  ext_ch_gain, frontend_mode_field;
  logic [4:0]  window_width;
  logic [10:0] window_offset;
  logic [1:0]  pulse_index, amp_reference_select, path_mode, idx;
  logic        integ_reverse, buffer_gain_select, integrator_buffer_enable;
  logic        per_channel_gain_enable, path_config_ok;
  logic [3:0]  ord;
  int          mismatches = 0;
  int          compares = 0;
  logic [15:0] amp_tab [4] = '{16'h1e04, 16'h1c95, 16'h1c66, 16'h1c37};
  logic [15:0] tim_tab [2] = '{16'hffff, 16'h0801};

  slotb_frontend_cfg DUT (
    .mclk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pulse_done,
    .ext_ch_gain, .ext_aux_buf_en, .integ_reverse, .pulse_index, .window_width,
    .window_offset, .frontend_mode_field, .buffer_gain_select, .integrator_buffer_enable,
    .per_channel_gain_enable, .amp_reference_select, .ch_gain, .signal_path_select,
    .path_mode, .path_config_ok);

  // Clock, 100 ns period
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // Compare and report
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Write strobe, left high for back-to-back use
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    if (mclk !== 1'b1) @(posedge mclk);
    reg_rd <= 1'b0;
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge mclk);
  endtask : wr

  // Read strobe, data checked in the following cycle
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    if (mclk !== 1'b1) @(posedge mclk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    chk(reg_rdata, e);
    @(posedge mclk);
  endtask : rd

  // End-of-pulse strobe held for n edges
  task automatic pulse(input logic [1:0] n);
    if (mclk !== 1'b1) @(posedge mclk);
    reg_wr <= 1'b0;
    pulse_done <= 1'b1;
    repeat (n) @(posedge mclk);
    idx = idx + n;
  endtask : pulse

  // Drop strobes and let outputs settle
  task automatic idle();
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    pulse_done <= 1'b0;
    @(posedge mclk);
    @(negedge mclk);
  endtask : idle

  // Path word against options and auxiliary enable
  task automatic path_case(input logic [15:0] amp, input logic aux, input logic [15:0] w,
                           input logic [1:0] m, input logic ok);
    wr(OFS_AMP_OPTIONS, amp);
    // Auxiliary enable changes just after a rising edge
    ext_aux_buf_en <= aux;
    wr(OFS_PATH_SELECT, w);
    idle();
    chk(signal_path_select, w);
    chk(16'(path_mode), 16'(m));
    chk(16'(path_config_ok), 16'(ok));
  endtask : path_case

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict

  // Watchdog against a hang
  initial begin
    #200000;
    mismatches++;
    give_verdict();
  end

  // Test sequence
  initial begin
    reset = 1'b1;
    {reg_wr, reg_rd, pulse_done, ext_aux_buf_en} = 4'h0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    ext_ch_gain = 6'h1b;
    idx = 2'd0;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    rd(OFS_POLARITY_ORDER, 16'h0000);
    rd(OFS_WINDOW_TIMING, 16'h2017);
    rd(OFS_AMP_OPTIONS, 16'h1c38);
    rd(OFS_PATH_SELECT, 16'hada5);
    idle();
    chk(16'(amp_reference_select), 16'h0003);
    chk(16'(ch_gain), 16'h0000);
    wr(8'h46, 16'hffff);
    rd(8'h46, 16'h0000);
    rd(OFS_PATH_SELECT, 16'hada5);
    foreach (tim_tab[i]) begin
      d = tim_tab[i];
      wr(OFS_WINDOW_TIMING, d);
      rd(OFS_WINDOW_TIMING, d);
      idle();
      chk(16'(window_width), 16'(d[15:11]));
      chk(16'(window_offset), 16'(d[10:0]));
    end
    foreach (amp_tab[i]) begin
      d = amp_tab[i];
      wr(OFS_AMP_OPTIONS, d);
      rd(OFS_AMP_OPTIONS, d);
      idle();
      chk(16'(frontend_mode_field), 16'(d[15:10]));
      chk(16'(buffer_gain_select), 16'(d[9]));
      chk(16'(integrator_buffer_enable), 16'(d[7]));
      chk(16'(per_channel_gain_enable), 16'(d[6]));
      chk(16'(amp_reference_select), 16'(d[5:4]));
      chk(16'(ch_gain), d[6] ? 16'({ext_ch_gain, d[1:0]}) : 16'({4{d[1:0]}}));
    end
    wr(OFS_AMP_OPTIONS, 16'h1c66);
    ext_ch_gain <= 6'h24;
    idle();
    chk(16'(ch_gain), 16'h0092);
    path_case(16'h1c34, 1'b0, PATH_AMP_ADC_DIR, 2'd2, 1'b1);
    path_case(16'h1cb4, 1'b0, PATH_AMP_ADC_DIR, 2'd2, 1'b0);
    path_case(16'h1cb4, 1'b1, PATH_AMP_ADC_BUF, 2'd1, 1'b1);
    path_case(16'h1cb4, 1'b0, PATH_AMP_ADC_BUF, 2'd1, 1'b0);
    path_case(16'h1c34, 1'b1, PATH_AMP_ADC_BUF, 2'd1, 1'b0);
    path_case(16'h1c34, 1'b0, 16'h1234, 2'd3, 1'b0);
    path_case(16'h1c34, 1'b0, PATH_FULL_ANALOG, 2'd0, 1'b1);
    wr(OFS_POLARITY_ORDER, 16'h0005);
    rd(OFS_POLARITY_ORDER, 16'h0005);
    ord = 4'h5;
    for (int k = 0; k < 8; k++) begin
      if (k == 6) wr(OFS_POLARITY_ORDER, 16'h000a);
      if (k == 6) ord = 4'ha;
      if (k == 7) pulse(2'd3);
      else if (k > 0) pulse(2'd1);
      idle();
      chk(16'(pulse_index), 16'(idx));
      chk(16'(integ_reverse), 16'(ord[idx]));
    end
    give_verdict();
  end
endmodule : slotb_frontend_cfg_tb_top

`default_nettype wire
